// [inc/asp_pkg.sv]
// shared constants for the audio sample stream port
package asp_pkg;
    localparam int ASP_DATA_W = 32;
    localparam int ASP_ID_W = 8;
    localparam int ASP_PRE_LSB = 0;
    localparam int ASP_PRE_MSB = 3;
    localparam int ASP_SMP_LSB = 4;
    localparam int ASP_SMP_MSB = 27;
    localparam int ASP_VAL_BIT = 28;
    localparam int ASP_USR_BIT = 29;
    localparam int ASP_CHS_BIT = 30;
    localparam int ASP_PAR_BIT = 31;
    localparam int ASP_CHAN_LSB = 0;
    localparam int ASP_CHAN_MSB = 3;
    localparam int ASP_STRM_LSB = 4;
    localparam int ASP_STRM_MSB = 7;
    localparam logic [3:0] ASP_PRE_BLOCK = 4'h1;
    localparam logic [3:0] ASP_PRE_SUB1 = 4'h2;
    localparam logic [3:0] ASP_PRE_SUB2 = 4'h3;
    localparam int ASP_CLK_PER_FS = 512;
endpackage : asp_pkg

// [design/asp_stage.sv]
// one-word register slice with valid/ready on both sides
`timescale 1ns/1ps
module asp_stage
    import asp_pkg::*;
#(
    parameter int W = ASP_DATA_W + ASP_ID_W
) (
    input wire logic clk_i, // clock
    input wire logic rst_b_i, // async reset, active low
    input wire logic srst_i, // sync reset, active high
    input wire logic [W-1:0] in_data_i, // incoming word
    input wire logic in_valid_i, // incoming valid
    output logic in_ready_o, // ready to take
    output logic [W-1:0] out_data_o, // held word
    output logic out_valid_o, // held valid
    input wire logic out_ready_i // downstream ready
);
    logic full_reg;
    logic [W-1:0] data_reg;
    wire take = in_valid_i && in_ready_o;
    wire give = full_reg && out_ready_i;

    // ready when empty or draining, so a single slot still streams every cycle
    assign in_ready_o = !srst_i && (!full_reg || out_ready_i);
    assign out_data_o = data_reg;
    assign out_valid_o = full_reg;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            full_reg <= 1'b0;
        end else if (srst_i) begin
            full_reg <= 1'b0;
        end else if (take) begin
            full_reg <= 1'b1;
        end else if (give) begin
            full_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            data_reg <= '0;
        end else if (take) begin
            data_reg <= in_data_i;
        end
    end
endmodule : asp_stage

// [design/asp_port.sv]
// audio sample stream port: ingress slave and egress master
`timescale 1ns/1ps
// Overview of operation
// - bits 3..0 of each word are the preamble code, 1 block start, 2 first, 3 second subframe.
// - bits 27..4 of each word carry the 24-bit audio sample on both streams.
// - bits 28..31 are validity, user, channel status and parity flags.
// - each word has an 8-bit id, low nibble channel, high nibble packet stream.
// - on ingress the source drives valid, the port drives ready, transfer when both high.
// - on egress the port drives valid, the sink drives ready, transfer when both high.
// - the audio logic is held in reset while the audio reset input is high.
// - the pipeline and error flag are reset while either streaming reset input is low; the field outputs keep their values.
module asp_port
    import asp_pkg::*;
(
    input wire logic clk_i, // audio clock, 512 x fs
    input wire logic rst_b_i, // async reset, active low
    input wire logic aud_rst_i, // audio reset, active high
    input wire logic ingress_rst_b_i, // ingress stream reset, active low
    input wire logic egress_rst_b_i, // egress stream reset, active low
    input wire logic [ASP_DATA_W-1:0] s_axis_tdata_i, // ingress word
    input wire logic [ASP_ID_W-1:0] s_axis_tid_i, // ingress id
    input wire logic s_axis_tvalid_i, // ingress valid
    output logic s_axis_tready_o, // ingress ready
    output logic [ASP_DATA_W-1:0] m_axis_tdata_o, // egress word
    output logic [ASP_ID_W-1:0] m_axis_tid_o, // egress id
    output logic m_axis_tvalid_o, // egress valid
    input wire logic m_axis_tready_i, // egress ready
    output logic [3:0] preamble_code_o, // preamble of last egress word
    output logic [ASP_SMP_MSB-ASP_SMP_LSB:0] sample_o, // sample of last egress word
    output logic [3:0] flags_o, // p,c,u,v of last egress word
    output logic [3:0] channel_o, // channel of last egress word
    output logic [3:0] stream_o, // packet stream of last egress word
    output logic preamble_err_o // sticky: bad preamble seen on ingress
);
    localparam int W = ASP_DATA_W + ASP_ID_W;
    localparam int SMP_W = ASP_SMP_MSB - ASP_SMP_LSB + 1;

    wire aud_hold = aud_rst_i;
    // either streaming reset holds the path
    wire ingress_hold = !ingress_rst_b_i;
    wire egress_hold = !egress_rst_b_i;
    // one shared pipeline, so any of the three empties all of it
    wire srst = aud_hold || ingress_hold || egress_hold;

    // ingress side
    wire [W-1:0] in_word = {s_axis_tid_i, s_axis_tdata_i};
    wire in_take;
    wire in_ready;

    // stage side
    wire [W-1:0] stage_out;
    wire stage_valid;
    wire stage_fill;
    wire stage_keep;

    // egress side
    wire out_idle;
    wire out_ready;
    wire out_load;
    wire out_drain;
    wire out_keep;

    // registered state
    logic ready_reg;
    wire ready_next;
    logic valid_reg;
    wire valid_next;
    logic [W-1:0] out_reg;

    assign s_axis_tready_o = ready_reg;
    assign in_take = s_axis_tvalid_i && ready_reg;

    // ready_reg high means the stage is empty,
    // so a take on ingress is refused only while srst is high
    asp_stage #(
        .W(W)
    ) asp_stage_i (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .srst_i(srst),
        .in_data_i(in_word),
        .in_valid_i(in_take),
        .in_ready_o(in_ready),
        .out_data_o(stage_out),
        .out_valid_o(stage_valid),
        .out_ready_i(out_ready)
    );

    // stage occupancy after this edge
    assign stage_fill = in_take && in_ready;
    assign stage_keep = stage_valid && !out_ready;

    // ready only when the stage will be empty
    // half rate on ingress, traded for a ready that comes from a flop
    assign ready_next = !srst && !stage_fill && !stage_keep;

    // output slot loads when empty or drained
    assign out_idle = !valid_reg;
    assign out_ready = out_idle || m_axis_tready_i;
    assign out_load = stage_valid && out_ready;
    assign out_drain = valid_reg && m_axis_tready_i;
    assign out_keep = valid_reg && !out_drain;
    assign valid_next = !srst && (out_load || out_keep);

    // egress word, id and valid from flops
    assign m_axis_tdata_o = out_reg[ASP_DATA_W-1:0];
    assign m_axis_tid_o = out_reg[W-1:ASP_DATA_W];
    assign m_axis_tvalid_o = valid_reg;

    // preamble decode of the ingress word
    wire [3:0] in_pre = s_axis_tdata_i[ASP_PRE_MSB:ASP_PRE_LSB];
    wire pre_block = in_pre == ASP_PRE_BLOCK;
    wire pre_first = in_pre == ASP_PRE_SUB1;
    wire pre_second = in_pre == ASP_PRE_SUB2;
    wire pre_known = pre_block || pre_first || pre_second;
    wire pre_bad = in_take && !pre_known;

    // preamble of the held egress word
    wire [3:0] out_pre = out_reg[ASP_PRE_MSB:ASP_PRE_LSB];
    // sample of the held egress word
    wire [SMP_W-1:0] out_smp = out_reg[ASP_SMP_MSB:ASP_SMP_LSB];

    // flags packed as p, c, u, v
    wire out_val = out_reg[ASP_VAL_BIT];
    wire out_usr = out_reg[ASP_USR_BIT];
    wire out_chs = out_reg[ASP_CHS_BIT];
    wire out_par = out_reg[ASP_PAR_BIT];
    wire [3:0] out_flags = {out_par, out_chs, out_usr, out_val};

    // id nibbles sit above the data word
    wire [3:0] out_chan = out_reg[ASP_DATA_W+ASP_CHAN_MSB:ASP_DATA_W+ASP_CHAN_LSB];
    wire [3:0] out_strm = out_reg[ASP_DATA_W+ASP_STRM_MSB:ASP_DATA_W+ASP_STRM_LSB];

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ready_reg <= 1'h0;
        end else begin
            ready_reg <= ready_next;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            valid_reg <= 1'h0;
        end else begin
            valid_reg <= valid_next;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            out_reg <= '0;
        end else if (out_load) begin
            out_reg <= stage_out;
        end
    end

    // fields follow the drain, so they show only words the sink took
    // preamble of the last drained word
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            preamble_code_o <= 4'h0;
        end else if (out_drain) begin
            preamble_code_o <= out_pre;
        end
    end

    // sample of the last drained word
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sample_o <= '0;
        end else if (out_drain) begin
            sample_o <= out_smp;
        end
    end

    // flags of the last drained word
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flags_o <= 4'h0;
        end else if (out_drain) begin
            flags_o <= out_flags;
        end
    end

    // channel of the last drained word
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            channel_o <= 4'h0;
        end else if (out_drain) begin
            channel_o <= out_chan;
        end
    end

    // packet stream of the last drained word
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stream_o <= 4'h0;
        end else if (out_drain) begin
            stream_o <= out_strm;
        end
    end

    // sticky error, cleared by any reset
    // a bad word taken in the clearing cycle still sets it
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            preamble_err_o <= 1'h0;
        end else if (pre_bad) begin
            preamble_err_o <= 1'h1;
        end else if (srst) begin
            preamble_err_o <= 1'h0;
        end
    end
endmodule : asp_port

// [verification/asp_port_properties.sv]
// assertions on the audio sample stream port
`timescale 1ns/1ps
module asp_port_properties
    import asp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic aud_rst_i,
    input wire logic ingress_rst_b_i,
    input wire logic egress_rst_b_i,
    input wire logic [ASP_DATA_W-1:0] s_axis_tdata_i,
    input wire logic s_axis_tvalid_i,
    input wire logic s_axis_tready_o,
    input wire logic [ASP_DATA_W-1:0] m_axis_tdata_o,
    input wire logic [ASP_ID_W-1:0] m_axis_tid_o,
    input wire logic m_axis_tvalid_o,
    input wire logic m_axis_tready_i,
    input wire logic [3:0] preamble_code_o,
    input wire logic [ASP_SMP_MSB-ASP_SMP_LSB:0] sample_o,
    input wire logic [3:0] flags_o,
    input wire logic [3:0] channel_o,
    input wire logic [3:0] stream_o,
    input wire logic preamble_err_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    wire ok = !aud_rst_i && ingress_rst_b_i && egress_rst_b_i;
    wire tk = s_axis_tvalid_i && s_axis_tready_o && ok;
    wire [3:0] pr = s_axis_tdata_i[3:0];
    wire [3:0] m_pre = m_axis_tdata_o[3:0];
    wire [23:0] m_smp = m_axis_tdata_o[27:4];
    wire [3:0] m_flg = m_axis_tdata_o[31:28];
    sequence drain;
        m_axis_tvalid_o && m_axis_tready_i && ok;
    endsequence
    a_egress_hold: assert property (m_axis_tvalid_o && !m_axis_tready_i && ok |=>
        $stable(m_axis_tdata_o) && $stable(m_axis_tid_o) && m_axis_tvalid_o) else $error("held");
    a_ingress_pause: assert property (tk |=> !s_axis_tready_o) else $error("ready");
    a_preamble_field: assert property (drain |=> preamble_code_o == $past(m_pre))
        else $error("preamble");
    a_sample_field: assert property (drain |=> sample_o == $past(m_smp))
        else $error("sample");
    a_flag_field: assert property (drain |=> flags_o == $past(m_flg))
        else $error("flags");
    a_id_fields: assert property (drain |=> {stream_o, channel_o} == $past(m_axis_tid_o))
        else $error("id");
    a_bad_preamble: assert property (tk && (pr == 4'h0 || pr > ASP_PRE_SUB2) |=> preamble_err_o)
        else $error("preamble flag");
    a_audio_reset: assert property (aud_rst_i |=> !m_axis_tvalid_o && !s_axis_tready_o)
        else $error("audio reset");
    a_stream_reset: assert property (!(ingress_rst_b_i && egress_rst_b_i) |=> !m_axis_tvalid_o)
        else $error("stream reset");
endmodule : asp_port_properties

// [verification/asp_sink_model.sv]
// downstream sink model for the egress stream
`timescale 1ns/1ps
module asp_sink_model (
    input wire logic clk_i, // clock
    input wire logic stall_i, // hold off the port
    input wire logic slow_i, // ready every other cycle
    output logic ready_o // egress ready
);
    logic tog = 1'b0;
    logic rdy_reg = 1'b0;
    // sink drives ready, changed only on the clock edge
    always @(posedge clk_i) begin
        tog <= !tog;
        rdy_reg <= !stall_i && !(slow_i && tog);
    end
    assign ready_o = rdy_reg;
endmodule : asp_sink_model

// [verification/asp_port_tb_top.sv]
// bench for the audio sample stream port
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
    $display("wrong value at %0t: %h", $time, a); end end
module asp_port_tb_top;
    import asp_pkg::*;
    logic clk_i = 0, rst_b_i = 0, ars = 0, irs = 1, ers = 1, vld = 0, stall = 0, slow = 0;
    logic [31:0] dat = 0, m_dat;
    logic [7:0] tid = 0, m_tid;
    logic rdy, m_vld, m_rdy, perr;
    logic [3:0] pre, flg, ch, st;
    logic [23:0] smp;
    int mismatches = 0, cmp_count = 0;
    asp_port asp_port_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .aud_rst_i(ars),
        .ingress_rst_b_i(irs), .egress_rst_b_i(ers), .s_axis_tdata_i(dat), .s_axis_tid_i(tid),
        .s_axis_tvalid_i(vld), .s_axis_tready_o(rdy), .m_axis_tdata_o(m_dat), .m_axis_tid_o(m_tid),
        .m_axis_tvalid_o(m_vld), .m_axis_tready_i(m_rdy), .preamble_code_o(pre), .sample_o(smp),
        .flags_o(flg), .channel_o(ch), .stream_o(st), .preamble_err_o(perr));
    asp_sink_model asp_sink_model_i (.clk_i(clk_i), .stall_i(stall), .slow_i(slow), .ready_o(m_rdy));
    // audio clock supplied by the bench, 512 x fs
    initial forever #5 clk_i = ~clk_i;
    task automatic step;
        @(posedge clk_i);
        #1;
    endtask : step
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    task automatic send(input logic [31:0] d, input logic [7:0] i);
        int n = 0;
        dat = d;
        tid = i;
        vld = 1;
        while (!rdy && n < 20) begin n++; step; end
        step;
        vld = 0;
        // let an edge pass so the next call does not raise valid in this step
        step;
        if (n == 20) begin mismatches++; end_of_test; end
    endtask : send
    task automatic recv(input logic [31:0] d, input logic [7:0] i);
        int n = 0;
        while (!(m_vld && m_rdy) && n < 20) begin n++; step; end
        if (n == 20) begin mismatches++; end_of_test; end
        `CHK(m_dat, d)
        `CHK(m_tid, i)
        step;
        `CHK(pre, d[3:0])
        `CHK(smp, d[27:4])
        `CHK(flg, d[31:28])
        `CHK({st, ch}, i)
    endtask : recv
    task automatic t_fields;
        for (int k = 0; k < 3; k++) begin
            slow = k[0];
            send({4'h5 ^ 4'(k), 24'hC0FFEE ^ 24'(k), 4'(k + 1)}, {4'(k), 4'hA ^ 4'(k)});
            recv({4'h5 ^ 4'(k), 24'hC0FFEE ^ 24'(k), 4'(k + 1)}, {4'(k), 4'hA ^ 4'(k)});
        end
    endtask : t_fields
    task automatic t_stall;
        stall = 1;
        send(32'hA123_4561, 8'h12);
        send(32'h5FED_CBA3, 8'h34);
        repeat (4) step;
        `CHK(rdy, 1'b0)
        `CHK(m_dat, 32'hA123_4561)
        stall = 0;
        recv(32'hA123_4561, 8'h12);
        recv(32'h5FED_CBA3, 8'h34);
    endtask : t_stall
    task automatic t_reset;
        for (int r = 0; r < 3; r++) begin
            stall = 1;
            send(32'h0000_0F77, 8'h01);
            `CHK(perr, 1'b1)
            ars = (r == 0);
            irs = (r != 1);
            ers = (r != 2);
            step;
            ars = 0;
            irs = 1;
            ers = 1;
            step;
            `CHK(m_vld, 1'b0)
            `CHK(perr, 1'b0)
            stall = 0;
            repeat (2) step;
        end
    endtask : t_reset
    initial begin
        repeat (2) @(posedge clk_i);
        #1 rst_b_i = 1;
        repeat (2) step;
        t_fields;
        t_stall;
        t_reset;
        end_of_test;
    end
endmodule : asp_port_tb_top
bind asp_port asp_port_properties asp_port_properties_i (.*);
